//--- design/lcdc_ctrl.sv
// LCD driver control: registers, display memory access and the common/segment scan.
// Notes on behaviour
// - Supply bit on drives; off grounds rows, segments and expansion lines.
// - Reset clears control bits, sets all-off.
// - Reference bit picks first or second level.
// - External supply ignores the reference bit.
// - Duty bits choose 1/8, 1/16 or 1/17.
// - All-on forces ON on every segment.
// - All-off forces OFF on every segment.
// - All-on wins over all-off.
// - At 1/8 duty, half bit picks page.
// - Otherwise half bit is plain storage.
// - Four-bit contrast, zero light, fifteen dark.
// - External supply ignores the contrast field.
// - Contrast and memory are not reset.
// - Expansion enable gates expanded-driver signals.
// - Memory bit one lights its dot.
// - Display memory is read/write general storage.
`timescale 1ns/10ps
module lcdc_ctrl #(
	parameter int SEGS = lcdc_pkg::LCDC_SEGS,
	parameter int ROW_CYCLES = lcdc_pkg::LCDC_ROW_CYCLES
) (
	// Clock, reset and enable.
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// Processor data-memory access.
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [lcdc_pkg::LCDC_DATA_W-1:0] i_wdata,
	output logic [lcdc_pkg::LCDC_DATA_W-1:0] o_rdata,
	// Supply option strap.
	input wire logic i_ext_supply,
	// Drive-voltage circuit controls.
	output logic o_drive_supply_on,
	output logic o_reference_level_select,
	output logic [lcdc_pkg::LCDC_DATA_W-1:0] o_contrast_level,
	output logic o_contrast_apply,
	// Panel lines.
	output logic [lcdc_pkg::LCDC_ROWS-1:0] o_row_select_lines,
	output logic [SEGS-1:0] o_dot_column_outputs,
	// Expanded external driver.
	output logic o_exp_frame_sync,
	output logic o_exp_row_strobe
);
	import lcdc_pkg::*;

	localparam int CNT_W = $clog2(ROW_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ROW_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [4:0] ROW_ZERO = 5'h00;

	// Strap synchroniser; only the second stage is used.
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_meta_nxt;
	logic ext_sync_nxt;

	// Control registers.
	logic [3:0] pwr_duty_r;
	logic [3:0] pwr_duty_nxt;
	logic [3:0] mode_r;
	logic [3:0] mode_nxt;
	logic [3:0] contrast_r;
	logic [3:0] contrast_nxt;
	logic [3:0] rdata_r;
	logic [3:0] rdata_nxt;

	// Scan state.
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [4:0] row_r;
	logic [4:0] row_nxt;
	logic [LCDC_ROWS-1:0] rows_out_r;
	logic [LCDC_ROWS-1:0] rows_out_nxt;
	logic [SEGS-1:0] segs_out_r;
	logic [SEGS-1:0] segs_out_nxt;
	logic sync_r;
	logic sync_nxt;
	logic strobe_r;
	logic strobe_nxt;
	logic supply_r;
	logic supply_nxt;
	logic ref_r;
	logic ref_nxt;
	logic apply_r;
	logic apply_nxt;
	logic [3:0] contrast_out_r;
	logic [3:0] contrast_out_nxt;

	// Decode and memory wiring.
	logic sel_pwr;
	logic sel_mode;
	logic sel_con;
	logic sel_mem;
	logic [LCDC_DATA_W-1:0] mem_rdata;
	logic [1:0] scan_page;
	logic [SEGS-1:0] row_bits;
	logic duty8;
	logic [4:0] last_row;

	always_comb begin
		sel_pwr = (i_addr == LCDC_ADDR_PWR_DUTY);
		sel_mode = (i_addr == LCDC_ADDR_MODE);
		sel_con = (i_addr == LCDC_ADDR_CONTRAST);
		sel_mem = (i_addr >= LCDC_DMEM_FIRST) && (i_addr <= LCDC_DMEM_LAST);
	end

	// The strap comes from outside the clock domain, so it passes two stages first.
	always_comb begin
		ext_meta_nxt = i_ext_supply;
		ext_sync_nxt = ext_meta_r;
	end

	always_comb begin
		duty8 = pwr_duty_r[LCDC_BIT_DUTY_HIGH];
		if (duty8) begin
			last_row = LCDC_LAST_ROW_DUTY8;
		end else if (pwr_duty_r[LCDC_BIT_DUTY_LOW]) begin
			last_row = LCDC_LAST_ROW_DUTY16;
		end else begin
			last_row = LCDC_LAST_ROW_DUTY17;
		end
	end

	// page choice at 1/8 duty; the bit is ignored at other duties.
	always_comb begin
		if (duty8) begin
			scan_page = {1'b0, mode_r[LCDC_BIT_HALF_SEL]};
		end else begin
			scan_page = row_r[4:3];
		end
	end

	// memory window.
	// Holes at page offsets 0x80-0xF7 alias onto populated words, so a stray write there corrupts the display.
	lcdc_dispmem #(
		.SEGS(SEGS)
	) u_mem (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_we(i_wr && sel_mem),
		.i_idx({i_addr[LCDC_DMEM_PAGE_LSB+1:LCDC_DMEM_PAGE_LSB],
			i_addr[LCDC_DMEM_WORD_W-1:0]}),
		.i_wdata(i_wdata),
		.o_rdata(mem_rdata),
		.i_page(scan_page),
		.i_row(row_r),
		.o_row_bits(row_bits)
	);

	// register writes and side-effect-free reads.
	// A read in the same cycle as a write to that register returns the old value.
	always_comb begin
		pwr_duty_nxt = pwr_duty_r;
		mode_nxt = mode_r;
		contrast_nxt = contrast_r;
		rdata_nxt = rdata_r;
		if (i_wr && sel_pwr) begin
			pwr_duty_nxt = i_wdata;
		end
		if (i_wr && sel_mode) begin
			mode_nxt = i_wdata;
		end
		if (i_wr && sel_con) begin
			contrast_nxt = i_wdata;
		end
		if (i_rd) begin
			if (sel_pwr) begin
				rdata_nxt = pwr_duty_r;
			end else if (sel_mode) begin
				rdata_nxt = mode_r;
			end else if (sel_con) begin
				rdata_nxt = contrast_r;
			end else if (sel_mem) begin
				rdata_nxt = mem_rdata;
			end else begin
				rdata_nxt = LCDC_NIB_ZERO;
			end
		end
	end

	// Row scan and output shaping.
	// The counter free-runs with the supply off, so rows resume mid-dwell at power-on.
	always_comb begin
		cnt_nxt = cnt_r + CNT_W'(1);
		row_nxt = row_r;
		sync_nxt = 1'b0;
		strobe_nxt = 1'b0;
		if (cnt_r >= CNT_LAST) begin
			cnt_nxt = CNT_ZERO;
			strobe_nxt = 1'b1;
			if (row_r >= last_row) begin
				row_nxt = ROW_ZERO;
				sync_nxt = 1'b1;
			end else begin
				row_nxt = row_r + 5'h01;
			end
		end
		sync_nxt = sync_nxt && mode_r[LCDC_BIT_EXP_EN] && pwr_duty_r[LCDC_BIT_SUPPLY_ON];
		strobe_nxt = strobe_nxt && mode_r[LCDC_BIT_EXP_EN] && pwr_duty_r[LCDC_BIT_SUPPLY_ON];
		rows_out_nxt = '0;
		segs_out_nxt = '0;
		if (pwr_duty_r[LCDC_BIT_SUPPLY_ON]) begin
			rows_out_nxt[row_r] = 1'b1;
			if (mode_r[LCDC_BIT_ALL_ON]) begin
				segs_out_nxt = '1;
			end else if (mode_r[LCDC_BIT_ALL_OFF]) begin
				segs_out_nxt = '0;
			end else begin
				segs_out_nxt = row_bits;
			end
		end
		supply_nxt = pwr_duty_r[LCDC_BIT_SUPPLY_ON];
		// reference choice; ignored on external supply.
		ref_nxt = pwr_duty_r[LCDC_BIT_REF_SEL] && !ext_sync_r;
		apply_nxt = !ext_sync_r;
		// Forcing zero keeps an undefined or stale code away from an external supply.
		contrast_out_nxt = ext_sync_r ? LCDC_NIB_ZERO : contrast_r;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
		end else if (i_ce) begin
			ext_meta_r <= ext_meta_nxt;
			ext_sync_r <= ext_sync_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_duty_r <= LCDC_RST_PWR_DUTY;
			mode_r <= LCDC_RST_MODE;
			rdata_r <= LCDC_NIB_ZERO;
		end else if (i_ce) begin
			pwr_duty_r <= pwr_duty_nxt;
			mode_r <= mode_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// contrast has no reset, so it powers up undefined.
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			contrast_r <= contrast_nxt;
		end
	end

	// Outputs reset low so the panel sees ground until the supply bit is set.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= CNT_ZERO;
			row_r <= ROW_ZERO;
			rows_out_r <= '0;
			segs_out_r <= '0;
			sync_r <= 1'b0;
			strobe_r <= 1'b0;
			supply_r <= 1'b0;
			ref_r <= 1'b0;
			apply_r <= 1'b0;
			contrast_out_r <= LCDC_NIB_ZERO;
		end else if (i_ce) begin
			cnt_r <= cnt_nxt;
			row_r <= row_nxt;
			rows_out_r <= rows_out_nxt;
			segs_out_r <= segs_out_nxt;
			sync_r <= sync_nxt;
			strobe_r <= strobe_nxt;
			supply_r <= supply_nxt;
			ref_r <= ref_nxt;
			apply_r <= apply_nxt;
			contrast_out_r <= contrast_out_nxt;
		end
	end

	// The panel needs no settling logic here; software waits out the ramp.
	assign o_rdata = rdata_r;
	assign o_drive_supply_on = supply_r;
	assign o_reference_level_select = ref_r;
	assign o_contrast_level = contrast_out_r;
	assign o_contrast_apply = apply_r;
	assign o_row_select_lines = rows_out_r;
	assign o_dot_column_outputs = segs_out_r;
	assign o_exp_frame_sync = sync_r;
	assign o_exp_row_strobe = strobe_r;
endmodule

//--- design/lcdc_pkg.sv
// Shared constants for the LCD driver control block.
package lcdc_pkg;
	// Register addresses in the I/O window.
	localparam logic [15:0] LCDC_ADDR_PWR_DUTY = 16'hff60;
	localparam logic [15:0] LCDC_ADDR_MODE = 16'hff61;
	localparam logic [15:0] LCDC_ADDR_CONTRAST = 16'hff62;
	// Display memory window.
	localparam logic [15:0] LCDC_DMEM_FIRST = 16'hf000;
	localparam logic [15:0] LCDC_DMEM_LAST = 16'hf276;
	localparam int LCDC_DMEM_PAGE_LSB = 8;
	localparam int LCDC_DMEM_WORD_W = 7;
	localparam int LCDC_DMEM_IDX_W = 9;
	// Field positions of the power and duty register.
	localparam int LCDC_BIT_SUPPLY_ON = 0;
	localparam int LCDC_BIT_REF_SEL = 1;
	localparam int LCDC_BIT_DUTY_LOW = 2;
	localparam int LCDC_BIT_DUTY_HIGH = 3;
	// Field positions of the display mode register.
	localparam int LCDC_BIT_HALF_SEL = 0;
	localparam int LCDC_BIT_ALL_ON = 1;
	localparam int LCDC_BIT_ALL_OFF = 2;
	localparam int LCDC_BIT_EXP_EN = 3;
	// Reset values.
	localparam logic [3:0] LCDC_RST_PWR_DUTY = 4'h0;
	localparam logic [3:0] LCDC_RST_MODE = 4'h4;
	// Data width and scan geometry.
	localparam int LCDC_DATA_W = 4;
	localparam int LCDC_ROWS = 17;
	localparam int LCDC_SEGS = 60;
	localparam logic [4:0] LCDC_LAST_ROW_DUTY8 = 5'h07;
	localparam logic [4:0] LCDC_LAST_ROW_DUTY16 = 5'h0f;
	localparam logic [4:0] LCDC_LAST_ROW_DUTY17 = 5'h10;
	// Row dwell time and its cycle count at 50 MHz.
	localparam int LCDC_CLK_PERIOD_NS = 20;
	localparam int LCDC_ROW_TIME_NS = 20480;
	localparam int LCDC_ROW_CYCLES = LCDC_ROW_TIME_NS / LCDC_CLK_PERIOD_NS;
	localparam logic [3:0] LCDC_NIB_ZERO = 4'h0;
endpackage

//--- design/lcdc_dispmem.sv
// Display memory with a processor port and a whole-row read port.
`timescale 1ns/10ps
module lcdc_dispmem #(
	parameter int SEGS = lcdc_pkg::LCDC_SEGS
) (
	// Clock.
	input wire logic i_clk,
	input wire logic i_ce,
	// Processor port.
	input wire logic i_we,
	input wire logic [lcdc_pkg::LCDC_DMEM_IDX_W-1:0] i_idx,
	input wire logic [lcdc_pkg::LCDC_DATA_W-1:0] i_wdata,
	output logic [lcdc_pkg::LCDC_DATA_W-1:0] o_rdata,
	// Scan port.
	input wire logic [1:0] i_page,
	input wire logic [4:0] i_row,
	output logic [SEGS-1:0] o_row_bits
);
	import lcdc_pkg::*;

	localparam int DEPTH = 1 << LCDC_DMEM_IDX_W;

	// Contents are left undefined at reset; software fills the memory first.
	logic [LCDC_DATA_W-1:0] mem [0:DEPTH-1];

	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_idx] <= i_wdata;
		end
	end

	assign o_rdata = mem[i_idx];

	// Each segment owns two words per page: low word holds rows 0-3, high word rows 4-7.
	genvar g;
	generate
		for (g = 0; g < SEGS; g++) begin : g_seg
			assign o_row_bits[g] = mem[{i_page, 6'(g), i_row[2]}][i_row[1:0]];
		end
	endgenerate
endmodule

//--- dv/lcdc_ctrl_properties.sv
// Concurrent checks on the ports of the LCD driver control block.
`timescale 1ns/10ps
module lcdc_ctrl_checker #(
	parameter int SEGS = lcdc_pkg::LCDC_SEGS,
	parameter int ROW_CYCLES = lcdc_pkg::LCDC_ROW_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_wdata,
	input wire logic [3:0] o_rdata,
	input wire logic i_ext_supply,
	input wire logic o_drive_supply_on,
	input wire logic o_reference_level_select,
	input wire logic [3:0] o_contrast_level,
	input wire logic o_contrast_apply,
	input wire logic [16:0] o_row_select_lines,
	input wire logic [SEGS-1:0] o_dot_column_outputs,
	input wire logic o_exp_frame_sync,
	input wire logic o_exp_row_strobe
);
	import lcdc_pkg::*;
	logic [3:0] pwr_sh_r, mode_sh_r;
	logic [16:0] prev_rows_r;
	int cnt_r;
	logic row_step;
	logic step_seen_r;
	assign row_step = o_row_select_lines != prev_rows_r && |prev_rows_r && |o_row_select_lines;
	// Shadows let the read checks know the stored value without a bus model.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_sh_r <= 4'h0;
			mode_sh_r <= 4'h4;
			prev_rows_r <= '0;
			cnt_r <= 0;
			step_seen_r <= 1'b0;
		end else begin
			// A dwell is only whole once a row step has been seen since power-on.
			step_seen_r <= row_step || (step_seen_r && |o_row_select_lines);
			if (i_ce && i_wr && i_addr == LCDC_ADDR_PWR_DUTY)
				pwr_sh_r <= i_wdata;
			if (i_ce && i_wr && i_addr == LCDC_ADDR_MODE)
				mode_sh_r <= i_wdata;
			prev_rows_r <= o_row_select_lines;
			cnt_r <= (o_row_select_lines != prev_rows_r) ? 1 : cnt_r + 1;
		end
	end
	default clocking dcb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence s_wr(logic [15:0] a);
		i_ce && i_wr && i_addr == a;
	endsequence
	sequence s_rd(logic [15:0] a);
		i_ce && i_rd && i_addr == a;
	endsequence
	property p_blank;
		s_wr(LCDC_ADDR_PWR_DUTY) ##0 !i_wdata[0] |->
			##2 o_row_select_lines == '0 && o_dot_column_outputs == '0;
	endproperty
	a_blank: assert property (p_blank) else $error("panel driven after supply off");
	property p_rd_pwr;
		s_rd(LCDC_ADDR_PWR_DUTY) |=> o_rdata == $past(pwr_sh_r);
	endproperty
	a_rd_pwr: assert property (p_rd_pwr) else $error("power register read wrong");
	property p_rd_mode;
		s_rd(LCDC_ADDR_MODE) |=> o_rdata == $past(mode_sh_r);
	endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("mode register read wrong");
	property p_hole;
		s_rd(16'hff63) |=> o_rdata == 4'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	property p_all_on;
		s_wr(LCDC_ADDR_MODE) ##0 (i_wdata[1] && pwr_sh_r[0]) |-> ##2 &o_dot_column_outputs;
	endproperty
	a_all_on: assert property (p_all_on) else $error("all-on not shown");
	property p_all_off;
		s_wr(LCDC_ADDR_MODE) ##0 i_wdata[2:1] == 2'b10 |-> ##2 o_dot_column_outputs == '0;
	endproperty
	a_all_off: assert property (p_all_off) else $error("all-off not shown");
	property p_ref;
		o_reference_level_select |-> o_contrast_apply;
	endproperty
	a_ref: assert property (p_ref) else $error("reference used with external supply");
	property p_ext;
		(i_ext_supply && i_ce) [*4] |-> !o_contrast_apply && o_contrast_level == 4'h0;
	endproperty
	a_ext: assert property (p_ext) else $error("contrast used with external supply");
	property p_exp;
		!mode_sh_r[3] && !$past(mode_sh_r[3]) && !$past(mode_sh_r[3], 2) |->
			!o_exp_row_strobe && !o_exp_frame_sync;
	endproperty
	a_exp: assert property (p_exp) else $error("expansion signals while disabled");
	property p_stand;
		row_step && step_seen_r |-> cnt_r == ROW_CYCLES;
	endproperty
	a_stand: assert property (p_stand) else $error("row dwell wrong");
	property p_order;
		row_step |-> o_row_select_lines == {prev_rows_r[15:0], 1'b0} || o_row_select_lines == 17'h1;
	endproperty
	a_order: assert property (p_order) else $error("row order wrong");
endmodule
bind lcdc_ctrl lcdc_ctrl_checker #(.SEGS(SEGS), .ROW_CYCLES(ROW_CYCLES)) u_chk (.*);

//--- dv/lcdc_panel_model.sv
// Panel model that records the dots shown on each common row.
`timescale 1ns/10ps
module lcdc_panel_model (
	input wire logic i_clk,
	input wire logic i_clear,
	input wire logic [16:0] i_row_select_lines,
	input wire logic [59:0] i_dot_column_outputs,
	output logic [59:0] o_seen [17],
	output logic [16:0] o_hit
);
	always @(posedge i_clk) begin
		if (i_clear)
			o_hit <= '0;
		for (int r = 0; r < 17; r++) begin
			if (i_row_select_lines[r] === 1'b1) begin
				o_hit[r] <= 1'b1;
				o_seen[r] <= i_dot_column_outputs;
			end
		end
	end
endmodule

//--- dv/lcd_driver_control_tb.sv
// Self-checking bench for the LCD driver control block.
`timescale 1ns/10ps
module lcd_driver_control_tb;
	import lcdc_pkg::*;
	localparam int RC = 4;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_ce = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_ext_supply = 1'b0;
	logic clr = 1'b0;
	logic [15:0] i_addr = 16'h0000;
	logic [3:0] i_wdata = 4'h0;
	logic [3:0] o_rdata, o_contrast_level;
	logic o_drive_supply_on, o_reference_level_select, o_contrast_apply;
	logic o_exp_frame_sync, o_exp_row_strobe;
	logic [16:0] o_row_select_lines, hit;
	logic [59:0] o_dot_column_outputs;
	logic [59:0] seen [17];
	logic [7:0] lf = 8'h40;
	logic [7:0] cfg [8] = '{8'h10, 8'h59, 8'h90, 8'hd1, 8'h12, 8'h14, 8'h16, 8'h02};
	logic [3:0] mem_m [int];
	int num_errors = 0;
	int tests_run = 0;
	int strobes = 0;
	int syncs = 0;
	lcdc_ctrl #(.ROW_CYCLES(RC)) u_dut (.*);
	lcdc_panel_model u_panel (.i_clk(i_clk), .i_clear(clr), .i_row_select_lines(o_row_select_lines),
		.i_dot_column_outputs(o_dot_column_outputs), .o_seen(seen), .o_hit(hit));
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (clr) begin
			strobes = 0;
			syncs = 0;
		end else begin
			if (o_exp_row_strobe === 1'b1)
				strobes++;
			if (o_exp_frame_sync === 1'b1)
				syncs++;
		end
	end
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %0h expected %0h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		if (a >= LCDC_DMEM_FIRST && a <= LCDC_DMEM_LAST)
			mem_m[a] = d;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [3:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		chk(o_rdata, e, "read");
	endtask
	function automatic logic [63:0] exp_dots(input int r, input logic [3:0] pd, md);
		logic [63:0] v;
		int ad;
		v = '0;
		for (int s = 0; s < 60; s++) begin
			if (r == 16)
				ad = 'hf200 + 2 * s;
			else
				ad = 'hf000 + 256 * (pd[3] ? md[0] : r / 8) + 2 * s + (r % 8) / 4;
			v[s] = mem_m[ad][r == 16 ? 0 : r % 4];
		end
		if (md[1])
			v = {4'h0, {60{1'b1}}};
		else if (md[2])
			v = '0;
		return v;
	endfunction
	task automatic frame(input logic [3:0] pd, input logic [3:0] md);
		logic [16:0] eh;
		wr(LCDC_ADDR_PWR_DUTY, pd);
		wr(LCDC_ADDR_MODE, md);
		rd(LCDC_ADDR_MODE, md);
		// Settling wait after power-on, scaled down for simulation.
		repeat (100) @(posedge i_clk);
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		repeat (3 * 17 * RC) @(posedge i_clk);
		eh = pd[3] ? 17'h000ff : (pd[2] ? 17'h0ffff : 17'h1ffff);
		if (!pd[0])
			eh = '0;
		chk(hit, eh, "rows scanned");
		chk(strobes > 0, md[3] & pd[0], "expansion strobes");
		chk(syncs > 0, md[3] & pd[0], "expansion syncs");
		chk({o_drive_supply_on, o_reference_level_select}, {pd[0], pd[1]}, "supply");
		for (int r = 0; r < 17; r++) begin
			if (eh[r])
				chk(seen[r], exp_dots(r, pd, md), "row dots");
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#(20 * 20000);
		$display("unexpected at %0t: watchdog expired", $time);
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		chk(o_row_select_lines, 0, "rows at reset");
		rd(LCDC_ADDR_PWR_DUTY, 4'h0);
		rd(LCDC_ADDR_MODE, 4'h4);
		wr(16'hff63, 4'hf);
		rd(16'hff63, 4'h0);
		// Only populated locations are written; memory is set before use.
		for (int i = 0; i < 631; i++) begin
			if (i[7:0] < 8'h78 && (i[9:8] < 2 || !i[0])) begin
				lf = nxt(lf);
				wr(LCDC_DMEM_FIRST + 16'(i), lf[3:0]);
				rd(LCDC_DMEM_FIRST + 16'(i), lf[3:0]);
			end
		end
		for (int i = 0; i < 8; i++)
			frame(cfg[i][7:4], cfg[i][3:0]);
		lf = nxt(lf);
		wr(LCDC_ADDR_PWR_DUTY, 4'h3);
		wr(LCDC_ADDR_CONTRAST, lf[3:0]);
		rd(LCDC_ADDR_CONTRAST, lf[3:0]);
		chk(o_contrast_level, lf[3:0], "contrast");
		chk({o_contrast_apply, o_reference_level_select}, 2'h3, "reference");
		i_ext_supply <= 1'b1;
		repeat (5) @(posedge i_clk);
		chk({o_contrast_apply, o_reference_level_select, o_contrast_level}, 0, "external");
		report_and_stop();
	end
endmodule
